// >>> hw/debug_reset_ctrl.sv
`timescale 1ns/1ps
`include "debug_reset_regs.svh"
// Functional notes
// - After warm reset, raise lockstep alarm if lockstep and debug are enabled.
// - Alarm also needs CPU halted at trigger, or counters on and cycle count read.
// - Tool config request bit drives app reset; reset held while bit set.
// - A release of the request is always honoured, even on the first try.
// - Debug status halt settings cleared only by a tool write, debug reset or power-on reset.
// - CPU0 debug status halt bit set: firmware starts, then halts again at its stop point before boot ends.
module debug_reset_ctrl
	import debug_reset_pkg::*;
#(
	parameter int NUM_CPUS = 4,
	parameter int WARM_RESET_CYC = `WARM_RESET_CYCLES,
	parameter int FW_STOP_CYC = `FW_STOP_CYCLES,
	parameter int FW_BOOT_CYC = `FW_BOOT_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic TCK,
	input wire logic DEBUG_RESET,
	input wire logic DEBUG_ENABLE,
	input wire logic [NUM_CPUS-1:0] LOCKSTEP_ENABLE,
	input wire logic [NUM_CPUS-1:0] PERF_COUNTER_ENABLE,
	input wire logic [NUM_CPUS-1:0] CYCLE_COUNT_READ,
	input wire logic [NUM_CPUS-1:0] CPU_IDLE,
	input wire logic SYS_RESET_REQ,
	input wire logic APP_RESET_REQ_IN,
	input wire logic TOOL_INSTR_VALID,
	input wire logic [3:0] TOOL_INSTR,
	input wire logic [7:0] TOOL_DATA_IN,
	output logic [7:0] TOOL_DATA_OUT,
	output logic TOOL_WRITE_BUSY,
	output logic APP_RESET_TO_SCU,
	output logic WARM_RESET_ACTIVE,
	output logic [NUM_CPUS-1:0] CPU_HALTED,
	output logic FW_BOOT_ACTIVE,
	output logic FW_BOOT_DONE,
	output logic [NUM_CPUS-1:0] LOCKSTEP_ALARM
);

	// ----------------------------------------------------------------
	// Link side (tool clock)
	// ----------------------------------------------------------------
	logic supervisor_q;
	logic [`TOOL_CFG_WIDTH-1:0] tool_config_q;
	logic [7:0] tool_data_out_q;
	logic [3:0] stat_link;
	logic dbg_wr_busy;
	tool_instr_t instr;

	assign instr = tool_instr_t'(TOOL_INSTR);

	wire instr_super = TOOL_INSTR_VALID && (instr == INSTR_SUPERVISOR);
	wire instr_cfg = TOOL_INSTR_VALID && (instr == INSTR_SET_TOOL_CONFIG) && supervisor_q;
	wire instr_dbg = TOOL_INSTR_VALID && (instr == INSTR_SET_DEBUG_STATUS) && supervisor_q;
	wire instr_read = TOOL_INSTR_VALID && (instr == INSTR_READ_STATUS);

	// Supervisor access arms exactly one following instruction
	always_ff @(posedge TCK or negedge RST_N) begin
		if (!RST_N) begin
			supervisor_q <= 1'b0;
		end else if (TOOL_INSTR_VALID) begin
			supervisor_q <= instr_super;
		end
	end

	// Config bits are a plain level, so every write, set or release, lands as written.
	// Nothing here depends on how fast the link clock runs once the write is taken.
	always_ff @(posedge TCK or negedge RST_N) begin
		if (!RST_N) begin
			tool_config_q <= `TOOL_CFG_RESET;
		end else if (instr_cfg) begin
			tool_config_q <= TOOL_DATA_IN;
		end
	end

	always_ff @(posedge TCK or negedge RST_N) begin
		if (!RST_N) begin
			tool_data_out_q <= 8'h00;
		end else if (instr_read) begin
			tool_data_out_q <= {stat_link, 4'h0};
		end
	end

	assign TOOL_DATA_OUT = tool_data_out_q;
	assign TOOL_WRITE_BUSY = dbg_wr_busy;

	// ----------------------------------------------------------------
	// Crossings
	// ----------------------------------------------------------------
	logic app_req_sys;
	logic dbg_wr_valid;
	logic [7:0] dbg_wr_data;
	logic [3:0] stat_sys;

	level_sync #(
		.W(1)
	) u_app_req_sync (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.d(tool_config_q[`TOOL_CFG_APP_RESET_BIT]),
		.q(app_req_sys)
	);

	level_sync #(
		.W(4)
	) u_stat_sync (
		.clk(TCK),
		.rst_n(RST_N),
		.d(stat_sys),
		.q(stat_link)
	);

	// Halt settings travel as a whole word so no CPU sees a half-written value
	word_handshake #(
		.W(8)
	) u_dbg_wr_xfer (
		.src_clk(TCK),
		.dst_clk(REF_CLK),
		.rst_n(RST_N),
		.src_valid(instr_dbg),
		.src_data(TOOL_DATA_IN),
		.src_busy(dbg_wr_busy),
		.dst_valid(dbg_wr_valid),
		.dst_data(dbg_wr_data)
	);

	// ----------------------------------------------------------------
	// Debug status halt settings (system clock)
	// ----------------------------------------------------------------
	logic [NUM_CPUS-1:0] dbg_halt_q;

	// Warm resets deliberately do not touch this register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dbg_halt_q <= '0;
		end else if (DEBUG_RESET) begin
			dbg_halt_q <= '0;
		end else if (dbg_wr_valid) begin
			dbg_halt_q <= dbg_wr_data[NUM_CPUS-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Warm reset sequencer
	// ----------------------------------------------------------------
	warm_state_t state_q, state_d;
	logic [`BOOT_CNT_WIDTH-1:0] cnt_q, cnt_d;

	wire app_reset_src = app_req_sys || APP_RESET_REQ_IN;
	wire warm_src = SYS_RESET_REQ || app_reset_src;
	wire reset_trigger = warm_src && (state_q != ST_RESET);
	wire reset_min_done = cnt_q >= `BOOT_CNT_WIDTH'(WARM_RESET_CYC - 1);
	wire boot_stop_point = cnt_q == `BOOT_CNT_WIDTH'(FW_STOP_CYC - 1);
	wire boot_end = cnt_q >= `BOOT_CNT_WIDTH'(FW_BOOT_CYC - 1);
	wire cpu0_halt_set = dbg_halt_q[`DBG_STATUS_CPU0_BIT];

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (reset_trigger) begin
			state_d = ST_RESET;
			cnt_d = '0;
		end else begin
			case (state_q)
				ST_RUN: begin
					cnt_d = '0;
				end
				ST_RESET: begin
					// Held for as long as any source asks, the tool's bit included
					if (!warm_src && reset_min_done) begin
						state_d = ST_BOOT;
						cnt_d = '0;
					end else if (!reset_min_done) begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				ST_BOOT: begin
					if (boot_stop_point && cpu0_halt_set) begin
						state_d = ST_BOOT_STOPPED;
					end else if (boot_end) begin
						state_d = ST_RUN;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				ST_BOOT_STOPPED: begin
					// Firmware resumes once CPU0's halt bit clears, by a tool write or a debug reset
					if (!cpu0_halt_set) begin
						state_d = ST_BOOT;
						cnt_d = cnt_q + 1'b1;
					end
				end
				default: begin
					state_d = ST_RUN;
					cnt_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_BOOT;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// CPU halt state
	// ----------------------------------------------------------------
	logic [NUM_CPUS-1:0] halted_now;
	logic boot_done_q;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CPUS; gi++) begin : g_halt
			if (gi == 0) begin : g_cpu0
				assign halted_now[gi] = (state_q == ST_BOOT_STOPPED) ||
					((state_q == ST_RUN) && (dbg_halt_q[gi] || CPU_IDLE[gi]));
			end else begin : g_other
				assign halted_now[gi] = (state_q == ST_RUN) && (dbg_halt_q[gi] || CPU_IDLE[gi]);
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			boot_done_q <= 1'b0;
		end else if (state_q == ST_RESET) begin
			boot_done_q <= 1'b0;
		end else if ((state_q == ST_BOOT) && boot_end && !reset_trigger) begin
			boot_done_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Lockstep alarm after warm reset
	// ----------------------------------------------------------------
	logic [NUM_CPUS-1:0] halted_at_trig_q;
	logic dbg_en_at_trig_q;
	logic [NUM_CPUS-1:0] cycle_count_register_seen_q;
	logic [NUM_CPUS-1:0] alarm_q;
	logic alarm_armed_q;

	// Snapshot at the trigger edge, before the reset hides the halt state
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			halted_at_trig_q <= '0;
			dbg_en_at_trig_q <= 1'b0;
		end else if (reset_trigger) begin
			halted_at_trig_q <= halted_now | dbg_halt_q;
			dbg_en_at_trig_q <= DEBUG_ENABLE;
		end
	end

	// Cycle count reads with counters on are remembered until the next warm reset ends.
	// A read in the same cycle as the clear is kept.
	wire alarm_eval = alarm_armed_q && (state_q == ST_BOOT);
	wire [NUM_CPUS-1:0] cycle_count_register_hit = CYCLE_COUNT_READ & PERF_COUNTER_ENABLE;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cycle_count_register_seen_q <= '0;
		end else begin
			cycle_count_register_seen_q <= cycle_count_register_hit | (alarm_eval ? '0 : cycle_count_register_seen_q);
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			alarm_armed_q <= 1'b0;
		end else if (reset_trigger) begin
			alarm_armed_q <= 1'b1;
		end else if (alarm_eval) begin
			alarm_armed_q <= 1'b0;
		end
	end

	wire [NUM_CPUS-1:0] cond_b = PERF_COUNTER_ENABLE & cycle_count_register_seen_q;
	wire [NUM_CPUS-1:0] alarm_d = {NUM_CPUS{alarm_eval && dbg_en_at_trig_q}} & LOCKSTEP_ENABLE &
		(halted_at_trig_q | cond_b);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			alarm_q <= '0;
		end else begin
			alarm_q <= alarm_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic app_reset_q;
	logic warm_active_q;
	logic [NUM_CPUS-1:0] cpu_halted_q;
	logic boot_active_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			app_reset_q <= 1'b0;
			warm_active_q <= 1'b0;
			cpu_halted_q <= '0;
			boot_active_q <= 1'b0;
		end else begin
			app_reset_q <= app_req_sys;
			warm_active_q <= (state_d == ST_RESET);
			cpu_halted_q <= halted_now;
			boot_active_q <= (state_q == ST_BOOT) || (state_q == ST_BOOT_STOPPED);
		end
	end

	assign APP_RESET_TO_SCU = app_reset_q;
	assign WARM_RESET_ACTIVE = warm_active_q;
	assign CPU_HALTED = cpu_halted_q;
	assign FW_BOOT_ACTIVE = boot_active_q;
	assign FW_BOOT_DONE = boot_done_q;
	assign LOCKSTEP_ALARM = alarm_q;

	// Status word seen by the tool, crossed by level synchronisers
	assign stat_sys = {app_reset_q, warm_active_q, boot_done_q, (state_q == ST_BOOT_STOPPED)};

endmodule // debug_reset_ctrl

// >>> hw/debug_reset_pkg.sv
package debug_reset_pkg;

	// Warm reset sequencer, Gray coded along run -> reset -> boot -> boot stopped
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_RESET = 2'b01,
		ST_BOOT = 2'b11,
		ST_BOOT_STOPPED = 2'b10
	} warm_state_t;

	// Instructions from the external tool
	typedef enum logic [3:0] {
		INSTR_NOP = 4'h0,
		INSTR_SUPERVISOR = 4'h1,
		INSTR_SET_TOOL_CONFIG = 4'h2,
		INSTR_SET_DEBUG_STATUS = 4'h3,
		INSTR_READ_STATUS = 4'h4
	} tool_instr_t;

endpackage

// >>> hw/debug_reset_regs.svh
`ifndef DEBUG_RESET_REGS_SVH
`define DEBUG_RESET_REGS_SVH

// ----------------------------------------------------------------
// Tool configuration register layout
// ----------------------------------------------------------------
`define TOOL_CFG_WIDTH 8
`define TOOL_CFG_RESET 8'h00
`define TOOL_CFG_APP_RESET_BIT 7

// ----------------------------------------------------------------
// Debug status register layout (one halt bit per CPU)
// ----------------------------------------------------------------
`define DBG_STATUS_RESET 8'h00
`define DBG_STATUS_CPU0_BIT 0

// ----------------------------------------------------------------
// Status word returned to the tool
// ----------------------------------------------------------------
`define TOOL_STAT_APP_RESET_BIT 7
`define TOOL_STAT_WARM_RESET_BIT 6
`define TOOL_STAT_BOOT_DONE_BIT 5
`define TOOL_STAT_BOOT_STOP_BIT 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_MHZ 100
`define TCK_MIN_KHZ 1000
`define WARM_RESET_MIN_NS 200
`define FW_STOP_POINT_NS 500
`define FW_BOOT_NS 2000
`define WARM_RESET_CYCLES ((`WARM_RESET_MIN_NS * `REF_CLK_MHZ + 999) / 1000)
`define FW_STOP_CYCLES ((`FW_STOP_POINT_NS * `REF_CLK_MHZ + 999) / 1000)
`define FW_BOOT_CYCLES ((`FW_BOOT_NS * `REF_CLK_MHZ + 999) / 1000)
`define BOOT_CNT_WIDTH 12

`endif

// >>> hw/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // level_sync

// >>> hw/word_handshake.sv
`timescale 1ns/1ps
module word_handshake #(
	parameter int W = 8
) (
	input wire logic src_clk,
	input wire logic dst_clk,
	input wire logic rst_n,
	input wire logic src_valid,
	input wire logic [W-1:0] src_data,
	output logic src_busy,
	output logic dst_valid,
	output logic [W-1:0] dst_data
);
	logic req_tgl_q;
	logic [W-1:0] hold_q;
	logic ack_s1_q, ack_s2_q;
	logic req_s1_q, req_s2_q, req_s3_q;
	wire take = src_valid && !src_busy;
	wire arrive = req_s2_q ^ req_s3_q;

	assign src_busy = req_tgl_q ^ ack_s2_q;

	// ----------------------------------------------------------------
	// Source side: data held stable until the toggle comes back
	// ----------------------------------------------------------------
	always_ff @(posedge src_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_tgl_q <= 1'b0;
			hold_q <= '0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= req_s3_q;
			ack_s2_q <= ack_s1_q;
			if (take) begin
				req_tgl_q <= ~req_tgl_q;
				hold_q <= src_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// Destination side
	// ----------------------------------------------------------------
	always_ff @(posedge dst_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			dst_valid <= 1'b0;
			dst_data <= '0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			dst_valid <= arrive;
			if (arrive)
				dst_data <= hold_q;
		end
	end
endmodule // word_handshake

// >>> verif/debug_reset_ctrl_asserts.sv
`timescale 1ns/1ps
module debug_reset_ctrl_asserts #(
	parameter int NUM_CPUS = 4,
	parameter int WARM_RESET_CYC = 20
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic SYS_RESET_REQ,
	input wire logic APP_RESET_REQ_IN,
	input wire logic [NUM_CPUS-1:0] LOCKSTEP_ENABLE,
	input wire logic APP_RESET_TO_SCU,
	input wire logic WARM_RESET_ACTIVE,
	input wire logic [NUM_CPUS-1:0] CPU_HALTED,
	input wire logic FW_BOOT_ACTIVE,
	input wire logic FW_BOOT_DONE,
	input wire logic [NUM_CPUS-1:0] LOCKSTEP_ALARM
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Length of the current warm reset, checked when it ends
	logic [15:0] warm_len_q;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) warm_len_q <= 16'h0;
		else warm_len_q <= WARM_RESET_ACTIVE ? warm_len_q + 16'h1 : 16'h0;
	end
	sequence boot_entry;
		$fell(WARM_RESET_ACTIVE) ##1 FW_BOOT_ACTIVE;
	endsequence
	sequence alarm_seen;
		LOCKSTEP_ALARM != '0;
	endsequence
	chk_req_starts_reset: assert property ((SYS_RESET_REQ || APP_RESET_REQ_IN) |=> WARM_RESET_ACTIVE)
		else $error("warm reset request not taken");
	chk_scu_holds_reset: assert property (APP_RESET_TO_SCU |-> WARM_RESET_ACTIVE)
		else $error("device left reset while tool request set");
	chk_reset_min_len: assert property ($fell(WARM_RESET_ACTIVE) |-> warm_len_q >= WARM_RESET_CYC)
		else $error("warm reset too short");
	chk_boot_no_early: assert property (boot_entry |-> !FW_BOOT_DONE [*6])
		else $error("boot finished too early");
	chk_alarm_enabled_only: assert property (alarm_seen |-> (LOCKSTEP_ALARM & ~LOCKSTEP_ENABLE) == '0)
		else $error("alarm on cpu without lockstep");
	chk_alarm_one_pulse: assert property (alarm_seen |=> LOCKSTEP_ALARM == '0)
		else $error("alarm longer than one cycle");
	chk_alarm_after_boot: assert property (alarm_seen |-> $past(WARM_RESET_ACTIVE, 2) || $past(WARM_RESET_ACTIVE, 3))
		else $error("alarm not right after warm reset");
	chk_stop_blocks_done: assert property (CPU_HALTED[0] && FW_BOOT_ACTIVE |-> !FW_BOOT_DONE)
		else $error("boot done while firmware stopped");
	chk_warm_clears_done: assert property (WARM_RESET_ACTIVE |=> !FW_BOOT_DONE)
		else $error("boot done during warm reset");
endmodule // debug_reset_ctrl_asserts

bind debug_reset_ctrl debug_reset_ctrl_asserts #(.NUM_CPUS(NUM_CPUS), .WARM_RESET_CYC(WARM_RESET_CYC)) u_chk (
	.REF_CLK, .RST_N, .SYS_RESET_REQ, .APP_RESET_REQ_IN, .LOCKSTEP_ENABLE, .APP_RESET_TO_SCU,
	.WARM_RESET_ACTIVE, .CPU_HALTED, .FW_BOOT_ACTIVE, .FW_BOOT_DONE, .LOCKSTEP_ALARM
);

// >>> verif/tb_debug_reset_ctrl.sv
`timescale 1ns/1ps
module tb_debug_reset_ctrl
	import debug_reset_pkg::*;
;
	localparam int N = 4;
	logic ref_clk = 0, rst_n = 0, debug_reset = 0, debug_enable = 0, sys_req = 0, app_req = 0;
	logic [N-1:0] lse = 0, perf = 0, ccr = 0, idle = 0;
	logic tck, tiv, busy, app_scu, warm, boot_act, boot_done;
	logic [3:0] tinstr;
	logic [7:0] tdata, data_out;
	logic [N-1:0] halted, alarm, alarm_acc, exp_alarm, rd;
	logic de;
	int fail_count = 0, compares = 0, seed = 32'h9585ac8e;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) alarm_acc = alarm_acc | alarm;
	tool_link_model u_tool (.tck(tck), .valid(tiv), .instr(tinstr), .data(tdata));
	debug_reset_ctrl #(.NUM_CPUS(N), .WARM_RESET_CYC(4), .FW_STOP_CYC(3), .FW_BOOT_CYC(8)) DUT (
		.REF_CLK(ref_clk), .RST_N(rst_n), .TCK(tck), .DEBUG_RESET(debug_reset), .DEBUG_ENABLE(debug_enable),
		.LOCKSTEP_ENABLE(lse), .PERF_COUNTER_ENABLE(perf), .CYCLE_COUNT_READ(ccr), .CPU_IDLE(idle),
		.SYS_RESET_REQ(sys_req), .APP_RESET_REQ_IN(app_req), .TOOL_INSTR_VALID(tiv), .TOOL_INSTR(tinstr),
		.TOOL_DATA_IN(tdata), .TOOL_DATA_OUT(data_out), .TOOL_WRITE_BUSY(busy), .APP_RESET_TO_SCU(app_scu),
		.WARM_RESET_ACTIVE(warm), .CPU_HALTED(halted), .FW_BOOT_ACTIVE(boot_act), .FW_BOOT_DONE(boot_done),
		.LOCKSTEP_ALARM(alarm)
	);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function logic pick(int s);
		case (s)
			0: pick = app_scu;
			1: pick = boot_done;
			default: pick = halted[0];
		endcase
	endfunction
	task wait_for(input int s, input logic v);
		int i;
		for (i = 0; i < 2000 && pick(s) !== v; i++) @(negedge ref_clk);
		if (pick(s) !== v) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task warm_pulse(input bit use_app);
		@(posedge ref_clk);
		if (use_app) app_req <= 1'b1;
		else sys_req <= 1'b1;
		@(posedge ref_clk);
		app_req <= 1'b0;
		sys_req <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_for(1, 1'b1);
		check(halted, 8'h00);
		u_tool.write(INSTR_SET_TOOL_CONFIG, 8'h80, 0);
		repeat (10) @(posedge ref_clk);
		check(app_scu, 8'h00);
		u_tool.write(INSTR_SET_TOOL_CONFIG, 8'h80, 1);
		wait_for(0, 1'b1);
		repeat (40) @(posedge ref_clk);
		check(warm, 8'h01);
		u_tool.write(INSTR_READ_STATUS, 8'h00, 0);
		check(data_out, 8'hC0);
		// A single release must already free the device
		u_tool.write(INSTR_SET_TOOL_CONFIG, 8'h00, 1);
		wait_for(1, 1'b1);
		check(app_scu, 8'h00);
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			lse <= $random(seed);
			perf <= $random(seed);
			idle <= $random(seed);
			de = $random(seed);
			rd = $random(seed);
			debug_enable <= de;
			ccr <= rd;
			@(posedge ref_clk);
			ccr <= '0;
			repeat (2) @(posedge ref_clk);
			alarm_acc = '0;
			exp_alarm = lse & {N{de}} & (idle | (perf & rd));
			warm_pulse(k[0]);
			// Inputs move after the trigger; only trigger values count
			debug_enable <= ~de;
			idle <= ~idle;
			wait_for(1, 1'b0);
			wait_for(1, 1'b1);
			check(alarm_acc, exp_alarm);
		end
		@(posedge ref_clk);
		lse <= '0;
		idle <= '0;
		debug_enable <= 1'b1;
		u_tool.write(INSTR_SET_DEBUG_STATUS, 8'h01, 1);
		check(busy, 8'h00);
		alarm_acc = '0;
		warm_pulse(0);
		wait_for(2, 1'b0);
		wait_for(2, 1'b1);
		repeat (30) @(posedge ref_clk);
		check(alarm_acc, 8'h00);
		check({boot_act, boot_done}, 8'h02);
		u_tool.write(INSTR_READ_STATUS, 8'h00, 0);
		check(data_out, 8'h10);
		u_tool.write(INSTR_SET_DEBUG_STATUS, 8'h00, 1);
		wait_for(1, 1'b1);
		check(halted, 8'h00);
		u_tool.write(INSTR_SET_DEBUG_STATUS, 8'h01, 1);
		@(posedge ref_clk);
		debug_reset <= 1'b1;
		@(posedge ref_clk);
		debug_reset <= 1'b0;
		warm_pulse(1);
		wait_for(1, 1'b0);
		wait_for(1, 1'b1);
		check(halted, 8'h00);
		report_and_stop();
	end
endmodule // tb_debug_reset_ctrl

// >>> verif/tool_link_model.sv
`timescale 1ns/1ps
module tool_link_model
	import debug_reset_pkg::*;
(
	output logic tck,
	output logic valid,
	output logic [3:0] instr,
	output logic [7:0] data
);
	initial begin
		tck = 1'b0;
		valid = 1'b0;
		instr = 4'h0;
		data = 8'h00;
	end
	// Link clock only runs inside frames, 6 ns period; lines move just after each rising edge
	task pulse();
		#2.5 tck = 1'b0;
		#3 tck = 1'b1;
		#0.5;
	endtask
	// Valid stays up between back-to-back instructions
	task cmd(input logic [3:0] i, input logic [7:0] d);
		valid = 1'b1;
		instr = i;
		data = d;
		pulse();
	endtask
	// Supervisor arms the set instruction that follows back to back
	task write(input logic [3:0] i, input logic [7:0] d, input bit sup);
		#0.7;
		// Idle edges first, so the status synchroniser catches up after the clock stood still
		repeat (3) pulse();
		if (sup) cmd(INSTR_SUPERVISOR, 8'h5A);
		cmd(i, d);
		// Released lines show the inverse so stale data never looks valid
		valid = 1'b0;
		instr = ~i;
		data = ~d;
		// Extra edges let the crossing and busy flag settle
		repeat (10) pulse();
	endtask
endmodule // tool_link_model
